// *** hpt_pkg.sv ***
package hpt_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HPT_TX_ADJUST_OFS = 8'h70;
  localparam logic [7:0] HPT_TX_EMPH_OFS = 8'h71;
  localparam logic [7:0] HPT_RX_ADJUST_OFS = 8'h72;

  // ----------------------------------------------------------------
  // hardware reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] HPT_TX_ADJUST_RST = 8'h7C;
  localparam logic [7:0] HPT_TX_EMPH_RST = 8'h3C;
  localparam logic [7:0] HPT_RX_ADJUST_RST = 8'h92;

  // ----------------------------------------------------------------
  // writable bit masks, reserved bits are zero
  // ----------------------------------------------------------------
  localparam logic [7:0] HPT_TX_ADJUST_WMASK = 8'hFF;
  localparam logic [7:0] HPT_TX_EMPH_WMASK = 8'hBF;
  localparam logic [7:0] HPT_RX_ADJUST_WMASK = 8'h07;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HPT_TERM_LSB = 6;
  localparam int HPT_EDGE_LSB = 4;
  localparam int HPT_SWING_LSB = 0;
  localparam int HPT_ADVERT_BIT = 7;
  localparam int HPT_EMPH_WIDTH_LSB = 4;
  localparam int HPT_EMPH_ON_BIT = 3;
  localparam int HPT_EMPH_LEVEL_LSB = 0;
  localparam int HPT_EQ_LSB = 0;

  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int HPT_TERM_W = 2;
  localparam int HPT_EDGE_W = 2;
  localparam int HPT_SWING_W = 4;
  localparam int HPT_EMPH_WIDTH_W = 2;
  localparam int HPT_EMPH_LEVEL_W = 3;
  localparam int HPT_EQ_W = 3;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam int HPT_NUM_REGS = 3;
  localparam int HPT_IDX_TX_ADJUST = 0;
  localparam int HPT_IDX_TX_EMPH = 1;
  localparam int HPT_IDX_RX_ADJUST = 2;

endpackage

// *** hpt_cfg_reg.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// one tuning register with factory override
// ------------------------------------------------------------------
module hpt_cfg_reg #(
  parameter int DATA_W = 8,
  parameter logic [DATA_W-1:0] RST_VAL = '0,
  parameter logic [DATA_W-1:0] WR_MASK = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // factory value
  input wire logic otp_valid,
  input wire logic [DATA_W-1:0] otp_value,
  // write port
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  // stored value
  output logic [DATA_W-1:0] q
);

  logic [DATA_W-1:0] val_ff;
  logic [DATA_W-1:0] nxt_val;
  wire logic [DATA_W-1:0] reset_word;
  wire logic [DATA_W-1:0] write_word;

  // factory value wins over the hardware default, reserved bits stay put
  assign reset_word = otp_valid ? ((otp_value & WR_MASK) | (RST_VAL & ~WR_MASK)) : RST_VAL;
  assign write_word = (wr_data & WR_MASK) | (val_ff & ~WR_MASK);

  always_comb
  begin
    nxt_val = val_ff;
    if (rst)
    begin
      nxt_val = reset_word;
    end
    else if (wr_en)
    begin
      nxt_val = write_word;
    end
  end

  always_ff @(posedge clk)
  begin
    val_ff <= nxt_val;
  end

  assign q = val_ff;

endmodule // hpt_cfg_reg

// *** hpt_port_tuning_regs.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// high-speed port tuning register bank
// ------------------------------------------------------------------
module hpt_port_tuning_regs
  import hpt_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // factory programmed values
  input wire logic [HPT_NUM_REGS-1:0] otp_valid,
  input wire logic [DATA_W-1:0] otp_tx_adjust,
  input wire logic [DATA_W-1:0] otp_tx_emph,
  input wire logic [DATA_W-1:0] otp_rx_adjust,
  // chirp state of the transmitter
  input wire logic chirp_j_level,
  input wire logic chirp_k_level,
  // analog trim controls
  output logic [HPT_TERM_W-1:0] line_termination_trim,
  output logic [HPT_EDGE_W-1:0] tx_edge_rate_sel,
  output logic [HPT_SWING_W-1:0] tx_swing_sel,
  output logic charge_port_advert_en,
  output logic [HPT_EMPH_WIDTH_W-1:0] tx_emphasis_width_sel,
  output logic tx_emphasis_on,
  output logic [HPT_EMPH_LEVEL_W-1:0] tx_emphasis_level_sel,
  output logic [HPT_EQ_W-1:0] rx_equalizer_sel
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 8)
  begin : g_bad_data_w
    $error("hpt_port_tuning_regs needs DATA_W of 8");
  end
  if (ADDR_W < 8)
  begin : g_bad_addr_w
    $error("hpt_port_tuning_regs needs ADDR_W of at least 8");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam logic [HPT_NUM_REGS*8-1:0] OFS_TABLE = {HPT_RX_ADJUST_OFS, HPT_TX_EMPH_OFS, HPT_TX_ADJUST_OFS};
  localparam logic [HPT_NUM_REGS*8-1:0] RST_TABLE = {HPT_RX_ADJUST_RST, HPT_TX_EMPH_RST, HPT_TX_ADJUST_RST};
  localparam logic [HPT_NUM_REGS*8-1:0] MASK_TABLE = {HPT_RX_ADJUST_WMASK, HPT_TX_EMPH_WMASK, HPT_TX_ADJUST_WMASK};

  wire logic [HPT_NUM_REGS-1:0] hit;
  wire logic [HPT_NUM_REGS*DATA_W-1:0] otp_words;
  logic [DATA_W-1:0] regs [HPT_NUM_REGS];
  wire logic [DATA_W-1:0] sel_word;
  wire logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] rdata_ff;
  logic rvalid_ff;

  assign otp_words = {otp_rx_adjust, otp_tx_emph, otp_tx_adjust};

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < HPT_NUM_REGS; i++)
  begin : g_reg
    assign hit[i] = (reg_addr == ADDR_W'(OFS_TABLE[i*8 +: 8]));
    hpt_cfg_reg #(
      .DATA_W(DATA_W),
      .RST_VAL(RST_TABLE[i*8 +: 8]),
      .WR_MASK(MASK_TABLE[i*8 +: 8])
    ) u_reg (
      .clk(clk),
      .rst(rst),
      .otp_valid(otp_valid[i]),
      .otp_value(otp_words[i*DATA_W +: DATA_W]),
      .wr_en(reg_wr && hit[i]),
      .wr_data(reg_wdata),
      .q(regs[i])
    );
  end

  // ----------------------------------------------------------------
  // read path, unmapped offsets read zero
  // ----------------------------------------------------------------
  assign sel_word = hit[HPT_IDX_TX_ADJUST] ? regs[HPT_IDX_TX_ADJUST] :
                    hit[HPT_IDX_TX_EMPH] ? regs[HPT_IDX_TX_EMPH] :
                    hit[HPT_IDX_RX_ADJUST] ? regs[HPT_IDX_RX_ADJUST] : 8'h00;
  assign nxt_rdata = reg_rd ? sel_word : rdata_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= reg_rd;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // ----------------------------------------------------------------
  // static trim words
  // ----------------------------------------------------------------
  assign line_termination_trim = regs[HPT_IDX_TX_ADJUST][HPT_TERM_LSB +: HPT_TERM_W];
  assign tx_edge_rate_sel = regs[HPT_IDX_TX_ADJUST][HPT_EDGE_LSB +: HPT_EDGE_W];
  assign tx_swing_sel = regs[HPT_IDX_TX_ADJUST][HPT_SWING_LSB +: HPT_SWING_W];
  assign charge_port_advert_en = regs[HPT_IDX_TX_EMPH][HPT_ADVERT_BIT];
  assign tx_emphasis_width_sel = regs[HPT_IDX_TX_EMPH][HPT_EMPH_WIDTH_LSB +: HPT_EMPH_WIDTH_W];
  // emphasis is forced off while chirping
  assign tx_emphasis_on = regs[HPT_IDX_TX_EMPH][HPT_EMPH_ON_BIT] && !(chirp_j_level || chirp_k_level);
  assign tx_emphasis_level_sel = regs[HPT_IDX_TX_EMPH][HPT_EMPH_LEVEL_LSB +: HPT_EMPH_LEVEL_W];
  assign rx_equalizer_sel = regs[HPT_IDX_RX_ADJUST][HPT_EQ_LSB +: HPT_EQ_W];

endmodule // hpt_port_tuning_regs

// *** hpt_checker.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// tuning register bank checks
// ------------------------------------------------------------------
module hpt_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // factory and chirp
  input wire logic [2:0] otp_valid,
  input wire logic [7:0] otp_tx_adjust,
  input wire logic chirp_j_level,
  input wire logic chirp_k_level,
  // trims
  input wire logic [1:0] line_termination_trim,
  input wire logic [1:0] tx_edge_rate_sel,
  input wire logic [3:0] tx_swing_sel,
  input wire logic charge_port_advert_en,
  input wire logic [1:0] tx_emphasis_width_sel,
  input wire logic tx_emphasis_on,
  input wire logic [2:0] tx_emphasis_level_sel,
  input wire logic [2:0] rx_equalizer_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] tx_w;
  assign tx_w = {line_termination_trim, tx_edge_rate_sel, tx_swing_sel};
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read valid");
  unmapped_zero_a: assert property (
    (reg_rd && (reg_addr < 8'h70 || reg_addr > 8'h72)) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  tx_write_a: assert property (
    (reg_wr && reg_addr == 8'h70) |=> tx_w == $past(reg_wdata)) else $error("tx adjust trims wrong");
  emph_write_a: assert property (
    (reg_wr && reg_addr == 8'h71) |=> tx_emphasis_level_sel == $past(reg_wdata[2:0])
    && tx_emphasis_width_sel == $past(reg_wdata[5:4])) else $error("emphasis trims wrong");
  eq_write_a: assert property (
    (reg_wr && reg_addr == 8'h72) |=> rx_equalizer_sel == $past(reg_wdata[2:0])) else $error("equalizer trim wrong");
  chirp_gate_a: assert property (
    (chirp_j_level || chirp_k_level) |-> !tx_emphasis_on) else $error("emphasis on during chirp");
  trims_hold_a: assert property (
    !reg_wr |=> $stable(tx_w) && $stable(rx_equalizer_sel)) else $error("trims moved without write");
  otp_load_a: assert property (
    $fell(rst) |-> tx_w == ($past(otp_valid[0]) ? $past(otp_tx_adjust) : 8'h7C))
    else $error("tx adjust reset content wrong");
endmodule // hpt_checker

// *** hpt_port_tuning_regs_bench.sv ***
`timescale 1ns/1ps
module hpt_port_tuning_regs_bench;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, chirp_j_level = 1'b0, chirp_k_level = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] ov [3] = '{8'h00, 8'h00, 8'h00};
  logic [2:0] otp_valid = 3'h0;
  logic reg_rvalid, charge_port_advert_en, tx_emphasis_on;
  logic [1:0] line_termination_trim, tx_edge_rate_sel, tx_emphasis_width_sel;
  logic [3:0] tx_swing_sel;
  logic [2:0] tx_emphasis_level_sel, rx_equalizer_sel;
  logic [7:0] e [3];
  logic [7:0] wd;
  logic [7:0] q [$];
  int bad_count = 0, cmp_count = 0;
  localparam logic [7:0] RV [3] = '{8'h7C, 8'h3C, 8'h92};
  localparam logic [7:0] WM [3] = '{8'hFF, 8'hBF, 8'h07};
  hpt_port_tuning_regs dut_u (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .otp_valid, .otp_tx_adjust(ov[0]), .otp_tx_emph(ov[1]), .otp_rx_adjust(ov[2]), .chirp_j_level,
    .chirp_k_level, .line_termination_trim, .tx_edge_rate_sel, .tx_swing_sel, .charge_port_advert_en,
    .tx_emphasis_width_sel, .tx_emphasis_on, .tx_emphasis_level_sel, .rx_equalizer_sel);
  initial forever #4 clk = ~clk;
  function automatic logic [7:0] mrg(input logic [7:0] d, input int i);
    return (d & WM[i]) | (RV[i] & ~WM[i]);
  endfunction
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= 8'h70 + i[7:0];
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (i < 3) e[i] = mrg(d, i);
  endtask
  task automatic rd(input int i);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= 8'h70 + i[7:0];
    q.push_back(i < 3 ? e[i] : 8'h00);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic trims;
    #1;
    chk("tx", e[0], {line_termination_trim, tx_edge_rate_sel, tx_swing_sel});
    chk("emph", {e[1][7], 1'b0, e[1][5:4], e[1][3] & ~(chirp_j_level | chirp_k_level), e[1][2:0]},
      {charge_port_advert_en, 1'b0, tx_emphasis_width_sel, tx_emphasis_on, tx_emphasis_level_sel});
    chk("eq", {5'h00, e[2][2:0]}, {5'h00, rx_equalizer_sel});
  endtask
  task automatic rst_dut(input logic [2:0] v);
    @(posedge clk);
    rst <= 1'b1;
    otp_valid <= v;
    for (int i = 0; i < 3; i++) ov[i] <= 8'($urandom);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) e[i] = v[i] ? mrg(ov[i], i) : RV[i];
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
    if (reg_rvalid === 1'b1)
    begin
      if (q.size() > 0) chk("rdata", q.pop_front(), reg_rdata);
      else chk("rvalid", 8'h00, 8'h01);
    end
  initial
  begin
    void'($urandom(32'h35bd));
    foreach (RV[v])
    begin
      rst_dut(v == 0 ? 3'h0 : 3'h5 << (v - 1));
      for (int i = 0; i < 4; i++) rd(i);
      trims;
    end
    for (int k = 0; k < 32; k++)
    begin
      wd = (k < 4) ? 8'hFF : 8'($urandom);
      if (k % 4 == 1 && wd[2:0] > 3'h5) wd[2:0] = 3'h5;
      wr(k % 4, wd);
      trims;
      rd(k % 4);
    end
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      {chirp_j_level, chirp_k_level} <= c[1:0];
      trims;
    end
    for (int n = 0; n < 8 && q.size() > 0; n++) @(posedge clk);
    if (q.size() > 0) bad_count++;
    tally_and_finish;
  end
endmodule // hpt_port_tuning_regs_bench
bind hpt_port_tuning_regs hpt_checker chk_u (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .reg_rvalid, .otp_valid, .otp_tx_adjust, .chirp_j_level, .chirp_k_level, .line_termination_trim,
  .tx_edge_rate_sel, .tx_swing_sel, .charge_port_advert_en, .tx_emphasis_width_sel, .tx_emphasis_on,
  .tx_emphasis_level_sel, .rx_equalizer_sel);
